// ===== rtl/pfx_pkg.sv
// Shared constants and types for the level-1 data prefetch engine.
// Assumes a byte address split into cache-line number and line offset.
package pfx_pkg;

   // ----------------------------------------
   // Address and line geometry
   // ----------------------------------------
   localparam int ADDR_W   = 48;               // Byte address width
   localparam int LINE_OFS = 6;                // Offset bits inside a line
   localparam int LINE_W   = ADDR_W - LINE_OFS; // Line number width

   // ----------------------------------------
   // Miss tracking and stream defaults
   // ----------------------------------------
   localparam int MQ_DEPTH = 8;                // Outstanding misses, prefetches included
   localparam int SLOT_W   = 3;                // Index width of a miss slot
   localparam int NSTREAM  = 4;                // Hardware streams tracked at once
   localparam int INIT_PF  = 3;                // Prefetches issued when a stream forms
   localparam int MAX_DIST = 8;                // Ceiling of the fetch-ahead distance
   localparam int CNT_W    = 4;                // Width of credit and distance counters

   // ----------------------------------------
   // Request kinds from the load/store pipe
   // ----------------------------------------
   typedef enum logic [2:0] {
      PFX_DEMAND_LOAD             = 3'h0,
      PFX_DEMAND_STORE            = 3'h1,
      PFX_LOAD_PREFETCH_LEVEL0_OP = 3'h2,
      PFX_LOAD_PREFETCH_LEVEL1_OP = 3'h3,
      PFX_LOAD_PREFETCH_LEVEL2_OP = 3'h4,
      PFX_STORE_PREFETCH_OP       = 3'h5,
      PFX_NONTEMPORAL_PREFETCH_OP = 3'h6
   } pfx_kind_e;

endpackage

// ===== rtl/pfx_stream_table.sv
// Unit-stride stream tracker of the hardware prefetcher.
// Assumes one access per cycle and a requester that accepts prefetches
// through a valid/ready pair.
`timescale 1ns/10ps
module pfx_stream_table #(
   parameter int NSTREAM  = pfx_pkg::NSTREAM,
   parameter int INIT_PF  = pfx_pkg::INIT_PF,
   parameter int MAX_DIST = pfx_pkg::MAX_DIST
) (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_resetn,
   input  wire logic                        i_acc_valid,
   input  wire logic                        i_acc_train,
   input  wire logic                        i_acc_nt,
   input  wire logic [pfx_pkg::LINE_W-1:0]  i_acc_line,
   output logic                             o_pf_valid,
   output logic      [pfx_pkg::LINE_W-1:0]  o_pf_line,
   output logic                             o_pf_nt,
   input  wire logic                        i_pf_ready
);
   import pfx_pkg::*;

   localparam logic [CNT_W-1:0] INIT_CNT = CNT_W'(INIT_PF);
   localparam logic [CNT_W-1:0] MAX_CNT  = CNT_W'(MAX_DIST);
   localparam logic [CNT_W-1:0] ONE_CNT  = CNT_W'(1);
   localparam int               SEL_W    = (NSTREAM > 1) ? $clog2(NSTREAM) : 1;

   // ----------------------------------------
   // Stream state
   // ----------------------------------------
   logic [NSTREAM-1:0] vld_r, vld_nxt, nt_r, nt_nxt;
   logic [LINE_W-1:0]  last_r [NSTREAM];
   logic [LINE_W-1:0]  last_nxt [NSTREAM];
   logic [LINE_W-1:0]  next_r [NSTREAM];
   logic [LINE_W-1:0]  next_nxt [NSTREAM];
   logic [CNT_W-1:0]   cred_r [NSTREAM];
   logic [CNT_W-1:0]   cred_nxt [NSTREAM];
   logic [CNT_W-1:0]   dist_r [NSTREAM];
   logic [CNT_W-1:0]   dist_nxt [NSTREAM];
   logic [LINE_W-1:0]  cand_r, cand_nxt;
   logic               cand_vld_r, cand_vld_nxt;
   logic [SEL_W-1:0]   rr_r, rr_nxt;
   logic [NSTREAM-1:0] hit_v, catch_v;
   logic               any_hit, alloc_fire, sel_vld;
   logic [SEL_W-1:0]   sel, victim;

   // Per-stream match of the next sequential line, and catch-up test
   for (genvar s = 0; s < NSTREAM; s++) begin : g_match
      logic [LINE_W-1:0] ahead;
      assign hit_v[s]   = vld_r[s] && (i_acc_line == last_r[s] + LINE_W'(1));
      assign ahead      = next_r[s] - i_acc_line;
      assign catch_v[s] = hit_v[s] && (ahead <= LINE_W'(1)); // Demand reached frontier
   end

   assign any_hit    = i_acc_valid && (|hit_v);
   // Two consecutive line misses open a stream
   assign alloc_fire = i_acc_valid && i_acc_train && !(|hit_v) && cand_vld_r &&
                       (i_acc_line == cand_r + LINE_W'(1));

   // Lowest stream with credit issues; replacement takes a free slot first,
   // otherwise round robin, which keeps a thrashing pattern from pinning one slot.
   always_comb begin
      sel     = '0;
      sel_vld = 1'b0;
      victim  = rr_r;
      for (int s = NSTREAM - 1; s >= 0; s--) begin
         if (vld_r[s] && (cred_r[s] != '0)) begin
            sel     = SEL_W'(s);
            sel_vld = 1'b1;
         end
         if (!vld_r[s]) begin
            victim = SEL_W'(s);
         end
      end
   end

   assign o_pf_valid = sel_vld;
   assign o_pf_line  = next_r[sel];
   assign o_pf_nt    = nt_r[sel];

   // Next stream state: issue, propagate, adapt, allocate
   always_comb begin
      vld_nxt      = vld_r;
      nt_nxt       = nt_r;
      cand_nxt     = cand_r;
      cand_vld_nxt = cand_vld_r;
      rr_nxt       = rr_r;
      for (int s = 0; s < NSTREAM; s++) begin
         last_nxt[s] = last_r[s];
         next_nxt[s] = next_r[s];
         cred_nxt[s] = cred_r[s];
         dist_nxt[s] = dist_r[s];
         if (sel_vld && i_pf_ready && (sel == SEL_W'(s))) begin
            next_nxt[s] = next_r[s] + LINE_W'(1);
            cred_nxt[s] = cred_r[s] - ONE_CNT;
         end
         // Any hit or miss on the next line extends the stream
         if (i_acc_valid && hit_v[s]) begin
            last_nxt[s] = i_acc_line;
            if (cred_nxt[s] < MAX_CNT) begin
               cred_nxt[s] = cred_nxt[s] + ONE_CNT;
            end
            // Caught up: widen the distance by one extra line, capped
            if (catch_v[s] && (dist_r[s] < MAX_CNT)) begin
               dist_nxt[s] = dist_r[s] + ONE_CNT;
               if (cred_nxt[s] < MAX_CNT) begin
                  cred_nxt[s] = cred_nxt[s] + ONE_CNT;
               end
            end
         end
      end
      if (i_acc_valid && i_acc_train && !(|hit_v)) begin
         cand_nxt     = i_acc_line;
         cand_vld_nxt = !alloc_fire;
      end
      if (alloc_fire) begin
         vld_nxt[victim]  = 1'b1;
         nt_nxt[victim]   = i_acc_nt;
         last_nxt[victim] = i_acc_line;
         next_nxt[victim] = i_acc_line + LINE_W'(1);
         cred_nxt[victim] = INIT_CNT;
         dist_nxt[victim] = INIT_CNT;
         rr_nxt           = (rr_r == SEL_W'(NSTREAM - 1)) ? '0 : rr_r + SEL_W'(1);
      end
   end

   // Stream registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         vld_r      <= '0;
         nt_r       <= '0;
         cand_r     <= '0;
         cand_vld_r <= 1'b0;
         rr_r       <= '0;
         for (int s = 0; s < NSTREAM; s++) begin
            last_r[s] <= '0;
            next_r[s] <= '0;
            cred_r[s] <= '0;
            dist_r[s] <= '0;
         end
      end else begin
         vld_r      <= vld_nxt;
         nt_r       <= nt_nxt;
         cand_r     <= cand_nxt;
         cand_vld_r <= cand_vld_nxt;
         rr_r       <= rr_nxt;
         last_r     <= last_nxt;
         next_r     <= next_nxt;
         cred_r     <= cred_nxt;
         dist_r     <= dist_nxt;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_two_miss;
      i_acc_valid && i_acc_train && !any_hit ##1
      i_acc_valid && i_acc_train && !any_hit && (i_acc_line == $past(i_acc_line) + LINE_W'(1));
   endsequence

   AST_NEW_STREAM_BURST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      s_two_miss |=> o_pf_valid && (cred_r[$past(victim)] == INIT_CNT))
      else $error("new stream did not load its initial prefetch count");

   AST_NO_TRAIN_ON_HIT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_acc_valid && !i_acc_train |=> $stable(cand_r) && $stable(vld_r))
      else $error("non-training access changed training state");

   for (genvar s = 0; s < NSTREAM; s++) begin : g_chk
      AST_DIST_CAP: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
         dist_r[s] <= MAX_CNT && cred_r[s] <= MAX_CNT)
         else $error("stream distance above its ceiling");
      AST_PROPAGATE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
         i_acc_valid && hit_v[s] && !alloc_fire && !(sel_vld && sel == SEL_W'(s))
         && cred_r[s] < MAX_CNT |=> cred_r[s] > $past(cred_r[s]))
         else $error("access to next line did not extend stream");
   end

endmodule

// ===== rtl/pfx_prefetch_engine.sv
// Level-1 data prefetch engine: miss slots, software prefetch handling,
// fill disposition and the hardware stream prefetcher.
// Assumes the level-2 side accepts every read pulse and answers each slot
// with exactly one fill.
//
// Summary of operation
// - Every prefetch reads the whole containing line.
// - Load prefetch fills L1, later evicts to L2.
// - Store prefetch fills modified, evicts to L2.
// - Nontemporal miss from memory never evicts to L2.
// - Nontemporal L2 hit evicts back to L2.
// - Emulation and task-switched bits change nothing.
// - Prefetch fills never write an architectural register.
// - Train on misses, propagate on every access.
// - Two consecutive line misses start a stream.
// - Initial burst, then one prefetch per access.
// - Unit-stride accesses keep extending their stream.
// - Catch-up widens distance up to the ceiling.
// - Pending credit and distance counters drive adaptation.
// - Software prefetches of every kind train.
// - Eight outstanding misses; further misses stall, hits still proceed.
// - Streams trained by nontemporal prefetches stay nontemporal.
`timescale 1ns/10ps
module pfx_prefetch_engine #(
   parameter int NSTREAM  = pfx_pkg::NSTREAM,
   parameter int INIT_PF  = pfx_pkg::INIT_PF,
   parameter int MAX_DIST = pfx_pkg::MAX_DIST
) (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_resetn,
   input  wire logic                        i_req_valid,
   input  wire logic [pfx_pkg::ADDR_W-1:0]  i_req_addr,
   input  wire pfx_pkg::pfx_kind_e          i_req_kind,
   input  wire logic                        i_req_l1_hit,
   input  wire logic                        i_emulation_control_bit,
   input  wire logic                        i_task_switched_control_bit,
   output logic                             o_req_ready,
   output logic                             o_rd_valid,
   output logic      [pfx_pkg::ADDR_W-1:0]  o_rd_addr,
   output logic      [pfx_pkg::SLOT_W-1:0]  o_rd_slot,
   output logic                             o_rd_modified,
   output logic                             o_rd_nontemporal,
   output logic                             o_rd_hw_pf,
   input  wire logic                        i_fill_valid,
   input  wire logic [pfx_pkg::SLOT_W-1:0]  i_fill_slot,
   input  wire logic                        i_fill_l2_hit,
   output logic                             o_fill_valid,
   output logic      [pfx_pkg::ADDR_W-1:0]  o_fill_addr,
   output logic                             o_fill_modified,
   output logic                             o_fill_evict_to_l2,
   output logic                             o_fill_reg_wb,
   output logic      [pfx_pkg::SLOT_W:0]    o_pending_count
);
   import pfx_pkg::*;

   localparam logic [LINE_OFS-1:0] LINE_ZERO = '0;

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   function automatic logic is_sw_pf(input pfx_kind_e k);
      is_sw_pf = (k != PFX_DEMAND_LOAD) && (k != PFX_DEMAND_STORE);
   endfunction

   function automatic logic is_store(input pfx_kind_e k);
      is_store = (k == PFX_DEMAND_STORE) || (k == PFX_STORE_PREFETCH_OP);
   endfunction

   logic [LINE_W-1:0]   req_line;
   logic                core_miss, core_alloc, acc_valid, acc_train, req_nt;
   logic                pf_valid, pf_ready, pf_nt, mq_full;
   logic [LINE_W-1:0]   pf_line;
   logic [SLOT_W-1:0]   free_slot;
   logic [SLOT_W:0]     pend_cnt;

   // Line number only; the byte offset is dropped so the read covers the line
   assign req_line   = i_req_addr[ADDR_W-1:LINE_OFS];
   // Control-register bits are deliberately not part of any decode
   assign core_miss  = i_req_valid && !i_req_l1_hit;
   assign core_alloc = core_miss && !mq_full;
   assign req_nt     = (i_req_kind == PFX_NONTEMPORAL_PREFETCH_OP);
   // Hits need no slot, so they never wait behind a full miss queue
   assign o_req_ready = i_req_l1_hit || !mq_full;
   assign acc_valid  = i_req_valid && o_req_ready;
   assign acc_train  = acc_valid && (!i_req_l1_hit || is_sw_pf(i_req_kind));
   // Demand misses win the slot; hardware prefetches fill idle slots only
   assign pf_ready   = !mq_full && !core_alloc;

   // ----------------------------------------
   // Hardware stream prefetcher
   // ----------------------------------------
   pfx_stream_table #(
      .NSTREAM  (NSTREAM),
      .INIT_PF  (INIT_PF),
      .MAX_DIST (MAX_DIST)
   ) u_streams (
      .i_sys_clk   (i_sys_clk),
      .i_resetn    (i_resetn),
      .i_acc_valid (acc_valid),
      .i_acc_train (acc_train),
      .i_acc_nt    (req_nt),
      .i_acc_line  (req_line),
      .o_pf_valid  (pf_valid),
      .o_pf_line   (pf_line),
      .o_pf_nt     (pf_nt),
      .i_pf_ready  (pf_ready)
   );

   // ----------------------------------------
   // Outstanding miss slots
   // ----------------------------------------
   logic [MQ_DEPTH-1:0] ent_vld_r, ent_vld_nxt;
   logic [MQ_DEPTH-1:0] ent_mod_r, ent_mod_nxt;
   logic [MQ_DEPTH-1:0] ent_nt_r, ent_nt_nxt;
   logic [MQ_DEPTH-1:0] ent_pf_r, ent_pf_nxt;
   logic [MQ_DEPTH-1:0] ent_hw_r, ent_hw_nxt;
   logic [LINE_W-1:0]   ent_line_r [MQ_DEPTH];
   logic [LINE_W-1:0]   ent_line_nxt [MQ_DEPTH];

   // Lowest free slot, full flag and pending count
   always_comb begin
      free_slot = '0;
      pend_cnt  = '0;
      for (int i = MQ_DEPTH - 1; i >= 0; i--) begin
         if (!ent_vld_r[i]) begin
            free_slot = SLOT_W'(i);
         end
         pend_cnt = pend_cnt + (SLOT_W + 1)'(ent_vld_r[i]);
      end
      mq_full = (pend_cnt == (SLOT_W + 1)'(MQ_DEPTH));
   end

   logic              rd_valid_nxt, rd_mod_nxt, rd_nt_nxt, rd_hw_nxt;
   logic [LINE_W-1:0] rd_line_nxt;

   // Slot allocation on a read, release on its fill
   always_comb begin
      ent_vld_nxt  = ent_vld_r;
      ent_mod_nxt  = ent_mod_r;
      ent_nt_nxt   = ent_nt_r;
      ent_pf_nxt   = ent_pf_r;
      ent_hw_nxt   = ent_hw_r;
      ent_line_nxt = ent_line_r;
      rd_valid_nxt = 1'b0;
      rd_line_nxt  = req_line;
      rd_mod_nxt   = 1'b0;
      rd_nt_nxt    = 1'b0;
      rd_hw_nxt    = 1'b0;
      if (i_fill_valid) begin
         ent_vld_nxt[i_fill_slot] = 1'b0;
      end
      if (core_alloc) begin
         rd_valid_nxt = 1'b1;
         rd_mod_nxt   = is_store(i_req_kind);
         rd_nt_nxt    = req_nt;
         ent_pf_nxt[free_slot] = is_sw_pf(i_req_kind);
      end else if (pf_valid && pf_ready) begin
         rd_valid_nxt = 1'b1;
         rd_line_nxt  = pf_line;
         rd_nt_nxt    = pf_nt;
         rd_hw_nxt    = 1'b1;
         ent_pf_nxt[free_slot] = 1'b1;
      end
      if (rd_valid_nxt) begin
         ent_vld_nxt[free_slot]  = 1'b1;
         ent_mod_nxt[free_slot]  = rd_mod_nxt;
         ent_nt_nxt[free_slot]   = rd_nt_nxt;
         ent_hw_nxt[free_slot]   = rd_hw_nxt;
         ent_line_nxt[free_slot] = rd_line_nxt;
      end
   end

   // Fill disposition: only a nontemporal line served from memory skips L2
   logic              fl_valid_nxt, fl_mod_nxt, fl_evict_nxt, fl_wb_nxt;
   logic [LINE_W-1:0] fl_line_nxt;

   always_comb begin
      fl_valid_nxt = i_fill_valid;
      fl_line_nxt  = ent_line_r[i_fill_slot];
      fl_mod_nxt   = ent_mod_r[i_fill_slot];
      // Load, store and L2-hit nontemporal lines go back to L2 on eviction
      fl_evict_nxt = !(ent_nt_r[i_fill_slot] && !i_fill_l2_hit);
      // Prefetch fills touch the cache only, never a destination register
      fl_wb_nxt    = i_fill_valid && !ent_pf_r[i_fill_slot];
   end

   // Slot and output registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ent_vld_r          <= '0;
         ent_mod_r          <= '0;
         ent_nt_r           <= '0;
         ent_pf_r           <= '0;
         ent_hw_r           <= '0;
         for (int i = 0; i < MQ_DEPTH; i++) begin
            ent_line_r[i] <= '0;
         end
         o_rd_valid         <= 1'b0;
         o_rd_addr          <= '0;
         o_rd_slot          <= '0;
         o_rd_modified      <= 1'b0;
         o_rd_nontemporal   <= 1'b0;
         o_rd_hw_pf         <= 1'b0;
         o_fill_valid       <= 1'b0;
         o_fill_addr        <= '0;
         o_fill_modified    <= 1'b0;
         o_fill_evict_to_l2 <= 1'b0;
         o_fill_reg_wb      <= 1'b0;
         o_pending_count    <= '0;
      end else begin
         ent_vld_r          <= ent_vld_nxt;
         ent_mod_r          <= ent_mod_nxt;
         ent_nt_r           <= ent_nt_nxt;
         ent_pf_r           <= ent_pf_nxt;
         ent_hw_r           <= ent_hw_nxt;
         ent_line_r         <= ent_line_nxt;
         o_rd_valid         <= rd_valid_nxt;
         o_rd_addr          <= {rd_line_nxt, LINE_ZERO};
         o_rd_slot          <= free_slot;
         o_rd_modified      <= rd_mod_nxt;
         o_rd_nontemporal   <= rd_nt_nxt;
         o_rd_hw_pf         <= rd_hw_nxt;
         o_fill_valid       <= fl_valid_nxt;
         o_fill_addr        <= {fl_line_nxt, LINE_ZERO};
         o_fill_modified    <= fl_mod_nxt;
         o_fill_evict_to_l2 <= fl_evict_nxt;
         o_fill_reg_wb      <= fl_wb_nxt;
         o_pending_count    <= pend_cnt;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_store_pf_miss;
      i_req_valid && !i_req_l1_hit && !mq_full && i_req_kind == PFX_STORE_PREFETCH_OP;
   endsequence

   AST_LINE_READ: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      core_alloc |=> o_rd_valid && o_rd_addr == {$past(req_line), LINE_ZERO})
      else $error("read not issued for the whole containing line");

   AST_STORE_PF_MOD: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      s_store_pf_miss ##3 (i_fill_valid && i_fill_slot == $past(free_slot, 3))
      |=> o_fill_modified && o_fill_evict_to_l2)
      else $error("store prefetch fill not modified");

   AST_LOAD_TO_L2: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_fill_valid && !ent_nt_r[i_fill_slot] |=> o_fill_valid && o_fill_evict_to_l2)
      else $error("temporal fill not marked for L2 eviction");

   AST_NT_MEM_NO_L2: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_fill_valid && ent_nt_r[i_fill_slot] && !i_fill_l2_hit
      |=> o_fill_valid && !o_fill_evict_to_l2)
      else $error("nontemporal memory fill marked for L2 eviction");

   AST_NT_HIT_L2: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_fill_valid && ent_nt_r[i_fill_slot] && i_fill_l2_hit |=> o_fill_evict_to_l2)
      else $error("nontemporal L2-hit fill not returned to L2");

   AST_PF_NO_REG: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_fill_valid && ent_pf_r[i_fill_slot] |=> o_fill_valid && !o_fill_reg_wb)
      else $error("prefetch fill wrote a register");

   AST_FULL_STALL: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      (o_pending_count == (SLOT_W + 1)'(MQ_DEPTH)) && !i_fill_valid && !$past(i_fill_valid)
      |=> !o_rd_valid && (o_req_ready == i_req_l1_hit))
      else $error("read issued with all miss slots busy");

   AST_CR_IGNORED: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      core_alloc && i_emulation_control_bit && i_task_switched_control_bit |=> o_rd_valid)
      else $error("control-register bits blocked a miss");

   AST_HW_NT_TAG: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      !core_alloc && pf_valid && pf_ready |=> o_rd_hw_pf && o_rd_nontemporal == $past(pf_nt))
      else $error("hardware prefetch lost its nontemporal tag");

endmodule

// ===== bench/pfx_l2_model.sv
// Level-2 and memory side model: answers each line read with one fill.
// Assumes reads come as one-cycle pulses; i_stall holds every answer back.
`timescale 1ns/10ps
module pfx_l2_model (
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_resetn,
   input  wire logic                       i_rd_valid,
   input  wire logic [pfx_pkg::SLOT_W-1:0] i_rd_slot,
   input  wire logic                       i_stall,
   input  wire logic                       i_l2_hit,
   output logic                            o_fill_valid,
   output logic      [pfx_pkg::SLOT_W-1:0] o_fill_slot,
   output logic                            o_fill_l2_hit
);
   logic [pfx_pkg::SLOT_W-1:0] slot_q[$];
   // One fill a cycle in arrival order; idle lines toggle, never a stale copy
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         slot_q.delete();
         o_fill_valid  <= 1'b0;
         o_fill_slot   <= '0;
         o_fill_l2_hit <= 1'b0;
      end else begin
         o_fill_valid  <= 1'b0;
         o_fill_slot   <= ~o_fill_slot;
         o_fill_l2_hit <= ~o_fill_l2_hit;
         if (slot_q.size() > 0 && !i_stall) begin
            o_fill_valid  <= 1'b1;
            o_fill_slot   <= slot_q.pop_front();
            o_fill_l2_hit <= i_l2_hit;
         end
         if (i_rd_valid) begin
            slot_q.push_back(i_rd_slot);
         end
      end
   end
endmodule

// ===== bench/testbench.sv
// Self-checking bench of the prefetch engine with an L2 model behind it.
// Assumes one request at a time from the bench and a patient L2 model.
`timescale 1ns/10ps
module testbench;
   import pfx_pkg::*;
   typedef struct packed {
      pfx_kind_e kind;
      logic      l2h, md, nt, ev, wb;
   } pfx_row_s;
   logic                    sys_clk, resetn, valid, hit, emu, ts, stall, l2h;
   logic [ADDR_W-1:0]       addr;
   pfx_kind_e               kind;
   logic                    o_req_ready, o_rd_valid, o_rd_modified, o_rd_nontemporal;
   logic                    o_rd_hw_pf, fvalid, fl2h, o_fill_valid, o_fill_modified;
   logic                    o_fill_evict_to_l2, o_fill_reg_wb;
   logic [ADDR_W-1:0]       o_rd_addr, o_fill_addr;
   logic [SLOT_W-1:0]       o_rd_slot, fslot;
   logic [SLOT_W:0]         o_pending_count;
   logic [LINE_W:0]         hwq[$];
   int                      errors = 0, compares = 0, n;
   pfx_row_s                rows[8] = '{
      '{PFX_DEMAND_LOAD, 0, 0, 0, 1, 1}, '{PFX_DEMAND_STORE, 0, 1, 0, 1, 1},
      '{PFX_LOAD_PREFETCH_LEVEL0_OP, 0, 0, 0, 1, 0},
      '{PFX_LOAD_PREFETCH_LEVEL1_OP, 1, 0, 0, 1, 0},
      '{PFX_LOAD_PREFETCH_LEVEL2_OP, 0, 0, 0, 1, 0},
      '{PFX_STORE_PREFETCH_OP, 0, 1, 0, 1, 0},
      '{PFX_NONTEMPORAL_PREFETCH_OP, 0, 0, 1, 0, 0},
      '{PFX_NONTEMPORAL_PREFETCH_OP, 1, 0, 1, 1, 0}};

   pfx_prefetch_engine DUT (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_req_valid(valid),
      .i_req_addr(addr), .i_req_kind(kind), .i_req_l1_hit(hit),
      .i_emulation_control_bit(emu), .i_task_switched_control_bit(ts),
      .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_addr(o_rd_addr),
      .o_rd_slot(o_rd_slot), .o_rd_modified(o_rd_modified),
      .o_rd_nontemporal(o_rd_nontemporal), .o_rd_hw_pf(o_rd_hw_pf),
      .i_fill_valid(fvalid), .i_fill_slot(fslot), .i_fill_l2_hit(fl2h),
      .o_fill_valid(o_fill_valid), .o_fill_addr(o_fill_addr),
      .o_fill_modified(o_fill_modified), .o_fill_evict_to_l2(o_fill_evict_to_l2),
      .o_fill_reg_wb(o_fill_reg_wb), .o_pending_count(o_pending_count));
   pfx_l2_model l2 (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_rd_valid(o_rd_valid),
      .i_rd_slot(o_rd_slot), .i_stall(stall), .i_l2_hit(l2h), .o_fill_valid(fvalid),
      .o_fill_slot(fslot), .o_fill_l2_hit(fl2h));

   // Clock, 100 ns period
   initial begin
      sys_clk = 0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Hardware reads logged mid-cycle, where the pulse has settled
   always @(negedge sys_clk) if (o_rd_valid === 1'b1 && o_rd_hw_pf === 1'b1)
      hwq.push_back({o_rd_nontemporal, o_rd_addr[ADDR_W-1:LINE_OFS]});

   task automatic check(input logic [ADDR_W:0] seen, input logic [ADDR_W:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until the ready edge; valid stays up for back-to-back use
   task automatic req(input logic [ADDR_W-1:0] a, input pfx_kind_e k, input logic h);
      valid = 1;
      addr  = a;
      kind  = k;
      hit   = h;
      for (n = 0; o_req_ready !== 1'b1 && n < 50; n++) begin
         @(posedge sys_clk) #1;
      end
      @(posedge sys_clk) #1;
   endtask
   task automatic print_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      {valid, hit, emu, ts, stall, l2h} = '0;
      addr = '0;
      kind = PFX_DEMAND_LOAD;
      resetn = 0;
      repeat (3) @(posedge sys_clk);
      #1;
      check(o_rd_valid, 0);
      check(o_req_ready, 1);
      resetn = 1;
      // Every kind misses, the nontemporal one twice; control bits vary but must change nothing
      foreach (rows[i]) begin
         {emu, ts} = i[1:0];
         l2h = rows[i].l2h;
         req({i[7:0], 10'h0} + 48'h25, rows[i].kind, 0);
         valid = 0;
         check(o_rd_valid, 1);
         check(o_rd_addr, {i[7:0], 10'h0});
         check(o_rd_slot, 0);
         check(o_rd_hw_pf, 0);
         check(o_rd_modified, rows[i].md);
         check(o_rd_nontemporal, rows[i].nt);
         for (n = 0; o_fill_valid !== 1'b1 && n < 20; n++) @(posedge sys_clk) #1;
         check(o_fill_valid, 1);
         check(o_fill_addr, {i[7:0], 10'h0});
         check(o_fill_modified, rows[i].md);
         check(o_fill_evict_to_l2, rows[i].ev);
         check(o_fill_reg_wb, rows[i].wb);
      end
      // Stream from two line misses, then a hit extends it
      req(100 << 6, PFX_DEMAND_LOAD, 0);
      req(101 << 6, PFX_DEMAND_LOAD, 0);
      valid = 0;
      repeat (10) @(posedge sys_clk);
      #1;
      req(102 << 6, PFX_DEMAND_LOAD, 1);
      valid = 0;
      repeat (6) @(posedge sys_clk);
      #1;
      for (int j = 0; j < 4; j++) check(hwq[j], 102 + j);
      // Nontemporal prefetch hits still train, stream keeps the tag
      hwq.delete();
      req(200 << 6, PFX_NONTEMPORAL_PREFETCH_OP, 1);
      req(201 << 6, PFX_NONTEMPORAL_PREFETCH_OP, 1);
      valid = 0;
      repeat (10) @(posedge sys_clk);
      #1;
      check(hwq[0], {1'b1, 42'd202});
      // Eight misses fill every slot; the ninth waits
      stall = 1;
      for (int j = 0; j < 8; j++) req((300 + 4 * j) << 6, PFX_DEMAND_LOAD, 0);
      valid = 0;
      @(posedge sys_clk) #1;
      check(o_pending_count, 8);
      valid = 1;
      addr  = 400 << 6;
      #1;
      check(o_req_ready, 0);
      stall = 0;
      req(400 << 6, PFX_DEMAND_LOAD, 0);
      check(o_rd_addr, 400 << 6);
      print_verdict();
   end
   // Watchdog, far beyond the fewer than a hundred cycles the tests need
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
endmodule
